// file: logic/axerr_detector.sv
// Per-axis error detection, error code latch and stop method selection
`include "axerr_defines.svh"

// How it works
// - Over CW soft limit raises 0043
// - Over CCW soft limit raises 0044
// - Move without origin raises 0045, decelerate
// - Origin: search done, or abs servo lock
// - Abs: unlock then relock re-establishes origin
// - Move or manual command without servo lock raises 0046
// - Preset out of range raises 0047
// - Emergency stop input raises 0048
// - Missing or bad abs data raises 0049
// - Abs encoder parameter mismatch raises 0049
// - Flag bit 14 word n+10, code n+11
module axerr_detector
  import axerr_pkg::*;
#(
  parameter int ABS_TIMEOUT_CYC = (`AXERR_ABS_TIMEOUT_NS + `AXERR_CLK_NS - 1) / `AXERR_CLK_NS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire axerr_cmd_s cmd_i,
  input wire axerr_cfg_s cfg_i,
  input wire logic motion_started_i,
  input wire logic origin_search_done_i,
  input wire logic servo_lock_i,
  input wire logic error_reset_i,
  input wire logic estop_pin_i,
  input wire logic abs_data_valid_i,
  input wire logic abs_link_err_pin_i,
  input wire logic abs_request_i,
  output logic cmd_accept_o,
  output logic [15:0] status_word_o,
  output logic [15:0] error_code_o,
  output axerr_stop_e stop_o,
  output logic origin_ok_o
);
  localparam int CNT_W = $clog2(ABS_TIMEOUT_CYC + 1);

  initial begin
    if (ABS_TIMEOUT_CYC < 1) $error("axerr_detector: timeout must be at least one cycle");
  end

  function automatic logic is_move(axerr_op_e op);
    return op inside {AXERR_OP_MOVE, AXERR_OP_MANUAL, AXERR_OP_COORD_SET,
                      AXERR_OP_POS_CHANGE};
  endfunction

  typedef enum logic [1:0] {
    AXERR_ABS_IDLE,
    AXERR_ABS_WAIT
  } axerr_abs_e;

  logic [1:0] pins_sync;
  logic estop_s;
  logic link_err_s;

  axerr_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({estop_pin_i, abs_link_err_pin_i}),
    .sync_o(pins_sync)
  );
  assign estop_s = pins_sync[1];
  assign link_err_s = pins_sync[0];

  logic err_flag, next_err_flag;
  logic [15:0] err_code, next_err_code;
  axerr_stop_e stop, next_stop;
  logic accept, next_accept;
  logic origin, next_origin;
  logic servo_prev, next_servo_prev;
  logic estop_prev, next_estop_prev;
  axerr_abs_e abs_st, next_abs_st;
  logic [CNT_W-1:0] abs_cnt, next_abs_cnt;

  logic cw_soft_limit_fault, ccw_soft_limit_fault, origin_missing_fault;
  logic servo_fault, preset_range_fault, estop_fault, abs_encoder_link_fault;
  logic enc_abs, param_fault, abs_timeout;
  logic signed [`AXERR_POS_W-1:0] val;
  axerr_stop_e soft_stop, estop_stop;

  always_comb begin
    enc_abs = cfg_i.enc_type != `AXERR_ENC_INC;
    val = cmd_i.value;
    cw_soft_limit_fault = cmd_i.valid
      && val > $signed(cfg_i.cw_limit);
    ccw_soft_limit_fault = cmd_i.valid
      && val < $signed(cfg_i.ccw_limit);
    origin_missing_fault = cmd_i.valid && is_move(cmd_i.op) && !origin;
    servo_fault = cmd_i.valid && cmd_i.op inside {AXERR_OP_MOVE, AXERR_OP_MANUAL}
      && !servo_lock_i;
    // preset window; outranks the soft limits
    preset_range_fault = cmd_i.valid && cmd_i.op == AXERR_OP_PRESET
      && (val > $signed(cfg_i.preset_max) || val < $signed(cfg_i.preset_min));
    // new stop input, or operation attempted while held
    estop_fault = (estop_s && !estop_prev) || (estop_s && cmd_i.valid);
    param_fault = enc_abs && cfg_i.enc_type != cfg_i.drv_enc_type;
    abs_timeout = abs_st == AXERR_ABS_WAIT && abs_cnt == CNT_W'(ABS_TIMEOUT_CYC);
    // parameter mismatch, no data, or link error during reception
    abs_encoder_link_fault = param_fault || abs_timeout
      || (abs_st == AXERR_ABS_WAIT && link_err_s);
    // decel before motion, accumulated pulse after
    soft_stop = motion_started_i ? AXERR_STOP_ACCUM : AXERR_STOP_DECEL;
    estop_stop = cfg_i.estop_sel_emg == `AXERR_ESTOP_SEL_EMG ? AXERR_STOP_EMERG
      : AXERR_STOP_ACCUM;
  end

  // Origin tracking and abs read watchdog
  always_comb begin
    next_servo_prev = servo_lock_i;
    next_estop_prev = estop_s;
    next_origin = origin;
    if (!enc_abs) begin
      if (origin_search_done_i) next_origin = 1'b1;
    end else begin
      // abs origin on each lock edge with no parameter mismatch
      if (servo_lock_i && !servo_prev && !param_fault) next_origin = 1'b1;
      else if (!servo_lock_i) next_origin = 1'b0;
    end
    next_abs_st = abs_st;
    next_abs_cnt = abs_cnt;
    unique case (abs_st)
      AXERR_ABS_IDLE: begin
        next_abs_cnt = '0;
        if (abs_request_i && enc_abs) next_abs_st = AXERR_ABS_WAIT;
      end
      AXERR_ABS_WAIT: begin
        next_abs_cnt = abs_cnt + CNT_W'(1);
        if (abs_data_valid_i || abs_timeout || link_err_s) next_abs_st = AXERR_ABS_IDLE;
      end
    endcase
  end

  // Error latch; first error wins until reset
  always_comb begin
    next_err_flag = err_flag;
    next_err_code = err_code;
    next_stop = stop;
    next_accept = 1'b0;
    if (error_reset_i) begin
      next_err_flag = 1'b0;
      next_err_code = `AXERR_CODE_NONE;
      next_stop = AXERR_STOP_NONE;
    end
    // new events set over a reset in the same cycle
    if (!err_flag || error_reset_i) begin
      next_err_flag = 1'b1;
      if (estop_fault) begin
        next_err_code = `AXERR_CODE_ESTOP;
        next_stop = estop_stop;
      end else if (abs_encoder_link_fault) begin
        next_err_code = `AXERR_CODE_ABS_LINK;
        next_stop = AXERR_STOP_DECEL;
      end else if (servo_fault) begin
        next_err_code = `AXERR_CODE_SERVO;
        next_stop = AXERR_STOP_DECEL;
      end else if (origin_missing_fault) begin
        next_err_code = `AXERR_CODE_ORIGIN;
        next_stop = AXERR_STOP_DECEL;
      end else if (preset_range_fault) begin
        next_err_code = `AXERR_CODE_PRESET;
        next_stop = AXERR_STOP_DECEL;
      end else if (cw_soft_limit_fault) begin
        next_err_code = `AXERR_CODE_CW_SOFT;
        next_stop = soft_stop;
      end else if (ccw_soft_limit_fault) begin
        next_err_code = `AXERR_CODE_CCW_SOFT;
        next_stop = soft_stop;
      end else begin
        next_err_flag = error_reset_i ? 1'b0 : err_flag;
        // accept only with no error pending
        next_accept = cmd_i.valid && !error_reset_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      err_flag <= 1'b0;
      err_code <= `AXERR_CODE_NONE;
      stop <= AXERR_STOP_NONE;
      accept <= 1'b0;
      origin <= 1'b0;
      servo_prev <= 1'b0;
      estop_prev <= 1'b0;
      abs_st <= AXERR_ABS_IDLE;
      abs_cnt <= '0;
    end else begin
      err_flag <= next_err_flag;
      err_code <= next_err_code;
      stop <= next_stop;
      accept <= next_accept;
      origin <= next_origin;
      servo_prev <= next_servo_prev;
      estop_prev <= next_estop_prev;
      abs_st <= next_abs_st;
      abs_cnt <= next_abs_cnt;
    end
  end

  // flag at bit 14, code in following word
  always_comb begin
    status_word_o = '0;
    status_word_o[`AXERR_FLAG_BIT] = err_flag;
  end
  assign error_code_o = err_code;
  assign stop_o = stop;
  assign cmd_accept_o = accept;
  assign origin_ok_o = origin;

  sequence s_cmd_no_origin;
    cmd_i.valid && is_move(cmd_i.op) && !origin && !err_flag && !estop_s
      && !abs_encoder_link_fault && !servo_fault;
  endsequence

  a_origin_code_raised: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_cmd_no_origin |=> err_code == `AXERR_CODE_ORIGIN && stop == AXERR_STOP_DECEL)
    else $error("origin fault not reported");
  a_flag_holds_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    status_word_o[`AXERR_FLAG_BIT] == (err_code != `AXERR_CODE_NONE))
    else $error("flag and code disagree");
  a_latched_until_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    err_flag && !error_reset_i |=> err_flag && $stable(err_code))
    else $error("error not held");
  a_no_accept_in_error: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_accept_o |-> !err_flag)
    else $error("command accepted during error");
  a_estop_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && estop_s && cmd_i.valid
      |=> err_code == `AXERR_CODE_ESTOP && stop == $past(estop_stop))
    else $error("stop input not reported");
  a_servo_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && !estop_fault && !abs_encoder_link_fault && servo_fault
      |=> err_code == `AXERR_CODE_SERVO)
    else $error("servo lock fault not reported");
  a_abs_timeout: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && !estop_fault && abs_timeout |=> err_code == `AXERR_CODE_ABS_LINK)
    else $error("abs link timeout not reported");
  a_param_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && !estop_fault && param_fault |=> err_code == `AXERR_CODE_ABS_LINK)
    else $error("parameter mismatch not reported");
  a_abs_origin_lock: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    enc_abs && !param_fault && servo_lock_i && !servo_prev |=> origin)
    else $error("abs origin not set on lock");
  a_inc_origin: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !enc_abs && origin_search_done_i |=> origin)
    else $error("search did not set origin");
  a_cw_stop_kind: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 err_code == `AXERR_CODE_CW_SOFT && $changed(err_code)
      |-> stop == ($past(motion_started_i) ? AXERR_STOP_ACCUM : AXERR_STOP_DECEL))
    else $error("cw stop method wrong");
  a_ccw_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 err_code == `AXERR_CODE_CCW_SOFT && $changed(err_code) |-> $past(ccw_soft_limit_fault))
    else $error("ccw code without cause");
  a_preset_code: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 err_code == `AXERR_CODE_PRESET && $changed(err_code) |-> $past(preset_range_fault))
    else $error("preset code without cause");

  // Preset beyond the CW soft limit but inside its window
  a_preset_over_cw: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && !estop_fault && !abs_encoder_link_fault && cmd_i.valid
      && cmd_i.op == AXERR_OP_PRESET && !preset_range_fault && cw_soft_limit_fault
      |=> err_code == `AXERR_CODE_CW_SOFT)
    else $error("preset over cw limit not reported");
  a_ccw_stop_kind: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 err_code == `AXERR_CODE_CCW_SOFT && $changed(err_code)
      |-> stop == ($past(motion_started_i) ? AXERR_STOP_ACCUM : AXERR_STOP_DECEL))
    else $error("ccw stop method wrong");
  a_estop_edge: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !err_flag && estop_s && !estop_prev
      |=> err_code == `AXERR_CODE_ESTOP && stop == $past(estop_stop))
    else $error("stop input edge not reported");

  // Link drop only counts while a read is outstanding
  sequence s_link_drop_in_read;
    !err_flag && !estop_fault && abs_st == AXERR_ABS_WAIT && link_err_s;
  endsequence

  a_link_in_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_link_drop_in_read |=> err_code == `AXERR_CODE_ABS_LINK && stop == AXERR_STOP_DECEL)
    else $error("link error during read not reported");
  a_clear_on_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    error_reset_i && !estop_fault && !abs_encoder_link_fault && !cmd_i.valid
      |=> !err_flag && err_code == `AXERR_CODE_NONE && stop == AXERR_STOP_NONE)
    else $error("error reset did not clear");
  a_abs_unlock_drop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    enc_abs && !servo_lock_i |=> !origin)
    else $error("abs origin kept after unlock");
  a_accept_has_cmd: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    cmd_accept_o |-> $past(cmd_i.valid))
    else $error("accept without command");
  a_origin_cause: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(origin) |-> $past(origin_search_done_i) || $past(servo_lock_i))
    else $error("origin set without cause");
endmodule

// file: shared/axerr_defines.svh
// Constants for the axis error detector
`ifndef AXERR_DEFINES_SVH
`define AXERR_DEFINES_SVH
`define AXERR_CODE_NONE 16'h0000
`define AXERR_CODE_CW_SOFT 16'h0043
`define AXERR_CODE_CCW_SOFT 16'h0044
`define AXERR_CODE_ORIGIN 16'h0045
`define AXERR_CODE_SERVO 16'h0046
`define AXERR_CODE_PRESET 16'h0047
`define AXERR_CODE_ESTOP 16'h0048
`define AXERR_CODE_ABS_LINK 16'h0049
`define AXERR_FLAG_BIT 4'hE
`define AXERR_POS_W 32
`define AXERR_ENC_INC 2'h0
`define AXERR_ENC_ABS 2'h1
`define AXERR_ENC_ABS_ALT 2'h2
`define AXERR_ABS_TIMEOUT_NS 1000000
`define AXERR_CLK_NS 8
`define AXERR_ESTOP_SEL_EMG 1'b1
`endif

// file: shared/axerr_pkg.sv
// Types for the axis error detector
`include "axerr_defines.svh"
package axerr_pkg;
  typedef enum logic [1:0] {
    AXERR_STOP_NONE,
    AXERR_STOP_DECEL,
    AXERR_STOP_ACCUM,
    AXERR_STOP_EMERG
  } axerr_stop_e;

  typedef enum logic [2:0] {
    AXERR_OP_MOVE,
    AXERR_OP_MANUAL,
    AXERR_OP_COORD_SET,
    AXERR_OP_POS_CHANGE,
    AXERR_OP_PRESET,
    AXERR_OP_ABS_READ
  } axerr_op_e;

  typedef struct packed {
    logic valid;
    axerr_op_e op;
    logic [`AXERR_POS_W-1:0] value;
  } axerr_cmd_s;

  typedef struct packed {
    logic [`AXERR_POS_W-1:0] cw_limit;
    logic [`AXERR_POS_W-1:0] ccw_limit;
    logic [`AXERR_POS_W-1:0] preset_max;
    logic [`AXERR_POS_W-1:0] preset_min;
    logic [1:0] enc_type;
    logic [1:0] drv_enc_type;
    logic estop_sel_emg;
  } axerr_cfg_s;
endpackage

// file: logic/axerr_sync.sv
// Two-flop synchroniser for a vector of pin levels
module axerr_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  initial begin
    if (WIDTH < 1) $error("axerr_sync: WIDTH must be at least 1");
  end

  always_comb begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end
endmodule

// file: tb/axerr_partner.sv
// Far-side model: stop input, encoder link and absolute data replies
module axerr_partner (
  input wire logic ref_clk_i,
  input wire logic abs_request_i,
  input wire logic stop_on_i,
  input wire logic link_bad_i,
  input wire logic [3:0] reply_dly_i,
  output logic estop_pin_o,
  output logic abs_link_err_pin_o,
  output logic abs_data_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  initial abs_data_valid_o = 1'b0;
  assign estop_pin_o = stop_on_i;
  assign abs_link_err_pin_o = link_bad_i;
  // delayed reply
  // Zero delay never answers, so a missing reply can be staged
  always @(posedge ref_clk_i) begin
    abs_data_valid_o <= 1'b0;
    if (abs_request_i && reply_dly_i != 4'h0) begin
      wait_cnt <= reply_dly_i;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
      abs_data_valid_o <= (wait_cnt == 4'h1);
    end
  end
endmodule

// file: tb/axerr_detector_test.sv
// Self-checking bench for the axis error detector
`include "axerr_defines.svh"
module axerr_detector_test import axerr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ABS_CYC = 8;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  axerr_cmd_s cmd = '0;
  axerr_cfg_s cfg = '{cw_limit: 32'h00001000, ccw_limit: 32'hFFFFF000,
    preset_max: 32'h00000800, preset_min: 32'hFFFFF800, enc_type: `AXERR_ENC_INC,
    drv_enc_type: `AXERR_ENC_INC, estop_sel_emg: `AXERR_ESTOP_SEL_EMG};
  logic motion = 1'b0;
  logic search_done = 1'b0;
  logic lock = 1'b1;
  logic err_rst = 1'b0;
  logic abs_req = 1'b0;
  logic stop_on = 1'b0;
  logic link_bad = 1'b0;
  logic [3:0] reply_dly = 4'h3;
  logic estop_pin, link_pin, abs_valid, accept, origin_ok;
  logic [15:0] status, code;
  axerr_stop_e stop;
  int error_cnt = 0;
  int comparisons = 0;

  axerr_partner far (.ref_clk_i(ref_clk_i), .abs_request_i(abs_req), .stop_on_i(stop_on),
    .link_bad_i(link_bad), .reply_dly_i(reply_dly), .estop_pin_o(estop_pin),
    .abs_link_err_pin_o(link_pin), .abs_data_valid_o(abs_valid));
  axerr_detector #(.ABS_TIMEOUT_CYC(ABS_CYC)) uut (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .cmd_i(cmd), .cfg_i(cfg), .motion_started_i(motion),
    .origin_search_done_i(search_done), .servo_lock_i(lock), .error_reset_i(err_rst),
    .estop_pin_i(estop_pin), .abs_data_valid_i(abs_valid), .abs_link_err_pin_i(link_pin),
    .abs_request_i(abs_req), .cmd_accept_o(accept), .status_word_o(status),
    .error_code_o(code), .stop_o(stop), .origin_ok_o(origin_ok));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // Idle edge first, so back-to-back sends never re-raise valid in one step;
  // outputs are read one falling edge after the command
  task automatic send(input axerr_op_e op, input logic [31:0] val);
    cyc(1);
    cmd = '{valid: 1'b1, op: op, value: val};
    cyc(1);
    cmd.valid = 1'b0;
  endtask

  task automatic exp(input logic [15:0] c, input axerr_stop_e s);
    chk(code, c);
    chk(status, (c == `AXERR_CODE_NONE) ? 16'h0000 : 16'h0001 << `AXERR_FLAG_BIT);
    chk(16'(stop), 16'(s));
  endtask

  task automatic clr;
    err_rst = 1'b1;
    cyc(1);
    err_rst = 1'b0;
    exp(`AXERR_CODE_NONE, AXERR_STOP_NONE);
  endtask

  task automatic t_origin;
    send(AXERR_OP_MOVE, 32'h0);
    exp(`AXERR_CODE_ORIGIN, AXERR_STOP_DECEL);
    send(AXERR_OP_MOVE, 32'h0);
    chk(16'(accept), 16'h0000);
    clr;
    search_done = 1'b1;
    cyc(1);
    search_done = 1'b0;
    chk(16'(origin_ok), 16'h0001);
    send(AXERR_OP_MOVE, 32'h00000100);
    chk(16'(accept), 16'h0001);
    $display("test origin finished");
  endtask

  task automatic t_servo;
    lock = 1'b0;
    send(AXERR_OP_MANUAL, 32'h0);
    exp(`AXERR_CODE_SERVO, AXERR_STOP_DECEL);
    send(AXERR_OP_PRESET, 32'h00000801);
    chk(code, `AXERR_CODE_SERVO);
    lock = 1'b1;
    clr;
    $display("test servo finished");
  endtask

  task automatic t_soft;
    // Odd ops run with motion started, so both stop methods show
    for (int i = 0; i < 4; i++) begin
      motion = i[0];
      send(axerr_op_e'(i), 32'h00001001);
      exp(`AXERR_CODE_CW_SOFT, motion ? AXERR_STOP_ACCUM : AXERR_STOP_DECEL);
      clr;
    end
    send(AXERR_OP_ABS_READ, 32'hFFFFEFFF);
    exp(`AXERR_CODE_CCW_SOFT, AXERR_STOP_ACCUM);
    motion = 1'b0;
    clr;
    send(AXERR_OP_MOVE, 32'h00001000);
    chk(16'(accept), 16'h0001);
    $display("test soft limit finished");
  endtask

  task automatic t_preset;
    send(AXERR_OP_PRESET, 32'hFFFFF7FF);
    exp(`AXERR_CODE_PRESET, AXERR_STOP_DECEL);
    clr;
    send(AXERR_OP_PRESET, 32'h00000800);
    chk(16'(accept), 16'h0001);
    cfg.preset_max = 32'h00002000;
    send(AXERR_OP_PRESET, 32'h00001001);
    exp(`AXERR_CODE_CW_SOFT, AXERR_STOP_DECEL);
    cfg.preset_max = 32'h00000800;
    clr;
    $display("test preset finished");
  endtask

  task automatic t_estop;
    stop_on = 1'b1;
    cyc(4);
    exp(`AXERR_CODE_ESTOP, AXERR_STOP_EMERG);
    clr;
    cfg.estop_sel_emg = 1'b0;
    send(AXERR_OP_MOVE, 32'h0);
    exp(`AXERR_CODE_ESTOP, AXERR_STOP_ACCUM);
    stop_on = 1'b0;
    cfg.estop_sel_emg = 1'b1;
    cyc(3);
    clr;
    $display("test stop input finished");
  endtask

  task automatic abs_read(input logic [3:0] dly);
    reply_dly = dly;
    abs_req = 1'b1;
    cyc(1);
    abs_req = 1'b0;
    cyc(ABS_CYC + 4);
  endtask

  task automatic t_abs;
    lock = 1'b0;
    cfg.enc_type = `AXERR_ENC_ABS;
    cfg.drv_enc_type = `AXERR_ENC_ABS;
    for (int i = 0; i < 2; i++) begin
      cyc(2);
      chk(16'(origin_ok), 16'h0000);
      lock = 1'b1;
      cyc(2);
      chk(16'(origin_ok), 16'h0001);
      lock = 1'b0;
    end
    lock = 1'b1;
    abs_read(4'h3);
    exp(`AXERR_CODE_NONE, AXERR_STOP_NONE);
    abs_read(4'hC);
    exp(`AXERR_CODE_ABS_LINK, AXERR_STOP_DECEL);
    cyc(4);
    clr;
    // Link fault with no read outstanding is not an error
    link_bad = 1'b1;
    cyc(4);
    exp(`AXERR_CODE_NONE, AXERR_STOP_NONE);
    abs_read(4'h3);
    exp(`AXERR_CODE_ABS_LINK, AXERR_STOP_DECEL);
    link_bad = 1'b0;
    cyc(3);
    clr;
    cfg.drv_enc_type = `AXERR_ENC_ABS_ALT;
    cyc(2);
    exp(`AXERR_CODE_ABS_LINK, AXERR_STOP_DECEL);
    cfg.drv_enc_type = `AXERR_ENC_ABS;
    cyc(1);
    clr;
    $display("test absolute encoder finished");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Tests need about 130 cycles; this leaves wide margin
  initial begin
    cyc(5000);
    error_cnt++;
    wrap_up;
  end

  initial begin
    cyc(12);
    reset_n_i = 1'b1;
    cyc(3);
    t_origin;
    t_servo;
    t_soft;
    t_preset;
    t_estop;
    t_abs;
    wrap_up;
  end
endmodule
